// *** csi_map.svh ***
// offsets, field positions, reset values and counts of the stack and interrupt entry block
// assumes: included by its bare name from every file that needs the layout
`ifndef CSI_MAP_SVH
`define CSI_MAP_SVH

// ----------------------------------------------------------------
// i/o space offsets (6-bit i/o address)
// ----------------------------------------------------------------
`define CSI_A_SP_LO 6'h10
`define CSI_A_SP_HI 6'h11
`define CSI_A_FLAGS 6'h12
`define CSI_A_CTRL 6'h13
`define CSI_A_IEN 6'h14
`define CSI_A_IFLG 6'h15

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define CSI_GIE_BIT 7
`define CSI_Z_BIT 1
`define CSI_C_BIT 0
`define CSI_VECTOR_TABLE_RELOCATE_BIT 1
`define CSI_SP_RESET 16'h10ff
`define CSI_FLAGS_RESET 8'h00
`define CSI_CTRL_RESET 8'h00
`define CSI_IEN_RESET 4'h0

// ----------------------------------------------------------------
// interrupt sources and vectors
// ----------------------------------------------------------------
`define CSI_NSRC 4
`define CSI_LEVEL_MASK 4'h8
`define CSI_BOOT_START 16'h1c00
`define CSI_VEC_STRIDE 16'h0002

// ----------------------------------------------------------------
// cycle counts
// ----------------------------------------------------------------
`define CSI_ENTRY_CYC 4
`define CSI_EXIT_CYC 4

`endif

// *** csi_pkg.sv ***
// types shared by the stack and interrupt entry block
// assumes: nothing; used by scoped names only
package csi_pkg;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_PUSH = 4'h1,
    OP_POP  = 4'h2,
    OP_CALL = 4'h3,
    OP_RET  = 4'h4,
    OP_HANDLER_EXIT_OP = 4'h5,
    OP_CLI  = 4'h6,
    OP_SEI  = 4'h7,
    OP_ALU  = 4'h8
  } csi_op_t;

  typedef enum logic [1:0] {
    ALU_ADD = 2'h0,
    ALU_SUB = 2'h1,
    ALU_AND = 2'h2,
    ALU_OR  = 2'h3
  } csi_alu_t;

  typedef enum logic [10:0] {
    S_IDLE  = 11'h001,
    S_PUSH  = 11'h002,
    S_POP   = 11'h004,
    S_WR_LO = 11'h008,
    S_WR_HI = 11'h010,
    S_VEC1  = 11'h020,
    S_VEC2  = 11'h040,
    S_RD_HI = 11'h080,
    S_RD_LO = 11'h100,
    S_FIN1  = 11'h200,
    S_FIN2  = 11'h400
  } csi_state_t;

endpackage

// *** csi_src_if.sv ***
// link between the core and one interrupt source slot
// assumes: one instance per source, driven on clk_sys
`timescale 1ns/1ps
interface csi_src_if;
  logic cond;
  logic en;
  logic clr;
  logic ack;
  logic flag;
  logic req;
  modport core (output cond, output en, output clr, output ack, input flag, input req);
  modport src (input cond, input en, input clr, input ack, output flag, output req);
endinterface

// *** csi_irq_src.sv ***
// one interrupt source slot: sticky flag or level request, gated by its enable
// assumes: cond comes from logic on clk_sys; LEVEL picks the source type
`timescale 1ns/1ps
module csi_irq_src #(
  parameter bit LEVEL = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  csi_src_if.src bus
);

  logic flag_reg;

  // ----------------------------------------------------------------
  // flag storage
  // ----------------------------------------------------------------
  // a new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= 1'b0;
    end else if (LEVEL) begin
      flag_reg <= 1'b0;
    end else if (bus.cond) begin
      flag_reg <= 1'b1;
    end else if (bus.clr || bus.ack) begin
      flag_reg <= 1'b0;
    end
  end

  assign bus.flag = LEVEL ? bus.cond : flag_reg;
  assign bus.req = (LEVEL ? bus.cond : flag_reg) && bus.en;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_flag_held: assert property (!LEVEL && bus.cond |=> flag_reg ##1 (flag_reg || $past(bus.clr)
    || $past(bus.ack)))
    else $error("flag event not held");
  a_w1c_clear: assert property (!LEVEL && bus.clr && !bus.cond |=> !flag_reg)
    else $error("write one did not clear flag");
  a_level_only: assert property (LEVEL && bus.req |-> bus.cond && bus.en)
    else $error("level request without condition");

endmodule

// *** csi_core.sv ***
// stack pointer, interrupt gating and entry/exit sequencing of an 8-bit core
// assumes: a sequencer on clk_sys issues ops and retire pulses; stack ram answers
// stk_rdata one cycle after stk_re; irq_cond from logic on clk_sys
//
// How it works
// - byte store writes then lowers pointer by one; byte load raises by one
// - calls and interrupt entry save return address, pointer lowered by two
// - subroutine and handler exit fetch return address, pointer raised by two
// - pointer starts at the last internal data sram address
// - pointer is two 8-bit read/write i/o registers, high and low
// - core runs straight from the chip clock, never divided
// - two-operand alu result is written back in the same cycle
// - a source is taken only with its enable and global enable set
// - lock bits suppress interrupts depending on program counter section
// - lower vector wins; reset first, comparator0 next
// - relocate bit moves vectors to boot start; fuse moves reset vector
// - accepting an interrupt clears global enable
// - handler exit sets global enable
// - vectoring clears the served sticky source flag; a level source flag follows its condition
// - writing one clears a sticky flag, zero leaves it; level flags ignore the write
// - flag events while disabled are held until served or cleared
// - level sources request only while their condition lasts
// - after handler exit one main instruction runs before another entry
// - flags register is never saved or restored by hardware
// - mask op takes effect at once, even against a same-cycle request
// - after unmask op the next instruction runs before any entry
// - entry takes four cycles pushing pc; waits for instruction end
// - handler exit takes four cycles, pops pc, raises pointer two, sets enable
`timescale 1ns/1ps
`include "csi_map.svh"
module csi_core (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic op_valid,
  input wire csi_pkg::csi_op_t op_code,
  input wire logic [7:0] op_data,
  input wire logic [15:0] ret_pc,
  input wire csi_pkg::csi_alu_t alu_sel,
  input wire logic [7:0] alu_a,
  input wire logic [7:0] alu_b,
  input wire logic insn_retire,
  input wire logic [15:0] pc_now,
  output logic busy,
  output logic irq_take,
  output logic vector_valid,
  output logic [15:0] irq_vector,
  output logic ret_valid,
  output logic [15:0] ret_pc_out,
  output logic [15:0] reset_vector,
  output logic [7:0] alu_result,
  output logic [15:0] stk_addr,
  output logic stk_we,
  output logic stk_re,
  output logic [7:0] stk_wdata,
  input wire logic [7:0] stk_rdata,
  input wire logic [5:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic [3:0] irq_cond,
  input wire logic reset_vector_relocate_fuse,
  input wire logic application_lock_bit,
  input wire logic boot_section_lock_bit
);

  localparam logic [3:0] LVL = `CSI_LEVEL_MASK;

  csi_pkg::csi_state_t st_reg;
  logic [15:0] stack_pointer_reg;
  logic [7:0] cpu_flags_register_reg;
  logic [7:0] core_control_register_reg;
  logic [3:0] ien_reg;
  logic [15:0] save_pc_reg;
  logic [7:0] wdata_reg;
  logic [15:0] irq_vector_reg;
  logic [15:0] ret_pc_reg;
  logic [15:0] reset_vector_reg;
  logic [7:0] alu_result_reg;
  logic [7:0] io_rdata_reg;
  logic entry_reg;
  logic handler_exit_op_reg;
  logic defer_reg;
  logic [2:0] pin_s1_reg;
  logic [2:0] pin_s2_reg;
  logic [3:0] req_vec;
  logic [3:0] flag_vec;
  logic [3:0] ack_vec;
  logic [3:0] flag_clr;
  logic [1:0] win_idx;
  logic acc;
  logic gie;
  logic vector_table_relocate;
  logic lock_block;
  logic in_boot;
  logic [8:0] alu_sum;

  // ----------------------------------------------------------------
  // pins and interrupt sources
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg <= 3'h0;
      pin_s2_reg <= 3'h0;
    end else begin
      pin_s1_reg <= {boot_section_lock_bit, application_lock_bit, reset_vector_relocate_fuse};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  assign flag_clr = (io_wr && io_addr == `CSI_A_IFLG) ? io_wdata[3:0] : 4'h0;

  for (genvar g = 0; g < `CSI_NSRC; g++) begin : g_src
    csi_src_if sif();
    assign sif.cond = irq_cond[g];
    assign sif.en = ien_reg[g];
    assign sif.clr = flag_clr[g];
    assign sif.ack = ack_vec[g];
    assign req_vec[g] = sif.req;
    assign flag_vec[g] = sif.flag;
    csi_irq_src #(.LEVEL(LVL[g])) u_src (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .bus(sif.src)
    );
  end

  // ----------------------------------------------------------------
  // priority and gating
  // ----------------------------------------------------------------
  always_comb begin
    win_idx = 2'h0;
    for (int i = `CSI_NSRC - 1; i >= 0; i--) begin
      if (req_vec[i]) begin
        win_idx = 2'(i);
      end
    end
  end

  assign gie = cpu_flags_register_reg[`CSI_GIE_BIT];
  assign vector_table_relocate = core_control_register_reg[`CSI_VECTOR_TABLE_RELOCATE_BIT];
  assign in_boot = (pc_now >= `CSI_BOOT_START);
  assign lock_block = (pin_s2_reg[1] && !vector_table_relocate && in_boot)
    || (pin_s2_reg[2] && vector_table_relocate && !in_boot);

  // entry only at an instruction end, never in the mask op's cycle
  assign irq_take = (st_reg == csi_pkg::S_IDLE) && insn_retire && gie && (|req_vec)
    && !defer_reg && !lock_block
    && !(op_valid && op_code == csi_pkg::OP_CLI);
  assign ack_vec = irq_take ? (4'h1 << win_idx) : 4'h0;
  assign acc = (st_reg == csi_pkg::S_IDLE) && op_valid && !irq_take;
  assign busy = (st_reg != csi_pkg::S_IDLE);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // clk_sys is the core clock itself, no divider in front of it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= csi_pkg::S_IDLE;
    end else begin
      case (st_reg)
        csi_pkg::S_IDLE: begin
          if (irq_take) begin
            st_reg <= csi_pkg::S_WR_LO;
          end else if (acc) begin
            case (op_code)
              csi_pkg::OP_PUSH: st_reg <= csi_pkg::S_PUSH;
              csi_pkg::OP_POP: st_reg <= csi_pkg::S_POP;
              csi_pkg::OP_CALL: st_reg <= csi_pkg::S_WR_LO;
              csi_pkg::OP_RET, csi_pkg::OP_HANDLER_EXIT_OP: st_reg <= csi_pkg::S_RD_HI;
              default: st_reg <= csi_pkg::S_IDLE;
            endcase
          end
        end
        csi_pkg::S_WR_LO: st_reg <= csi_pkg::S_WR_HI;
        csi_pkg::S_WR_HI: st_reg <= entry_reg ? csi_pkg::S_VEC1 : csi_pkg::S_IDLE;
        csi_pkg::S_VEC1: st_reg <= csi_pkg::S_VEC2;
        csi_pkg::S_RD_HI: st_reg <= csi_pkg::S_RD_LO;
        csi_pkg::S_RD_LO: st_reg <= csi_pkg::S_FIN1;
        csi_pkg::S_FIN1: st_reg <= csi_pkg::S_FIN2;
        default: st_reg <= csi_pkg::S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      entry_reg <= 1'b0;
      handler_exit_op_reg <= 1'b0;
    end else if (irq_take) begin
      entry_reg <= 1'b1;
    end else if (acc) begin
      entry_reg <= 1'b0;
      handler_exit_op_reg <= (op_code == csi_pkg::OP_HANDLER_EXIT_OP);
    end
  end

  // ----------------------------------------------------------------
  // stack pointer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stack_pointer_reg <= `CSI_SP_RESET;
    end else if (acc && (op_code == csi_pkg::OP_POP || op_code == csi_pkg::OP_RET
        || op_code == csi_pkg::OP_HANDLER_EXIT_OP)) begin
      stack_pointer_reg <= stack_pointer_reg + 16'h0001;
    end else if (st_reg == csi_pkg::S_RD_HI) begin
      stack_pointer_reg <= stack_pointer_reg + 16'h0001;
    end else if (stk_we) begin
      stack_pointer_reg <= stack_pointer_reg - 16'h0001;
    end else if (io_wr && io_addr == `CSI_A_SP_LO) begin
      stack_pointer_reg[7:0] <= io_wdata;
    end else if (io_wr && io_addr == `CSI_A_SP_HI) begin
      stack_pointer_reg[15:8] <= io_wdata;
    end
  end

  // only the return address goes to the stack, flags stay with software
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      save_pc_reg <= 16'h0000;
      wdata_reg <= 8'h00;
    end else if (irq_take || (acc && op_code == csi_pkg::OP_CALL)) begin
      save_pc_reg <= ret_pc;
      wdata_reg <= ret_pc[7:0];
    end else if (acc && op_code == csi_pkg::OP_PUSH) begin
      wdata_reg <= op_data;
    end else if (st_reg == csi_pkg::S_WR_LO) begin
      wdata_reg <= save_pc_reg[15:8];
    end
  end

  assign stk_addr = stack_pointer_reg;
  assign stk_wdata = wdata_reg;
  assign stk_we = (st_reg == csi_pkg::S_PUSH) || (st_reg == csi_pkg::S_WR_LO)
    || (st_reg == csi_pkg::S_WR_HI);
  assign stk_re = (st_reg == csi_pkg::S_POP) || (st_reg == csi_pkg::S_RD_HI)
    || (st_reg == csi_pkg::S_RD_LO);

  // ----------------------------------------------------------------
  // vectors and return address
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_vector_reg <= 16'h0000;
      ret_pc_reg <= 16'h0000;
      reset_vector_reg <= 16'h0000;
    end else begin
      reset_vector_reg <= pin_s2_reg[0] ? `CSI_BOOT_START : 16'h0000;
      if (irq_take) begin
        irq_vector_reg <= (vector_table_relocate ? `CSI_BOOT_START : 16'h0000)
          + 16'((16'(win_idx) + 16'h0001) * `CSI_VEC_STRIDE);
      end
      if (st_reg == csi_pkg::S_RD_LO) begin
        ret_pc_reg[15:8] <= stk_rdata;
      end
      if (st_reg == csi_pkg::S_FIN1) begin
        ret_pc_reg[7:0] <= stk_rdata;
      end
    end
  end

  assign irq_vector = irq_vector_reg;
  assign ret_pc_out = ret_pc_reg;
  assign reset_vector = reset_vector_reg;
  assign vector_valid = (st_reg == csi_pkg::S_VEC2);
  assign ret_valid = (st_reg == csi_pkg::S_FIN2);

  // ----------------------------------------------------------------
  // flags, control and alu
  // ----------------------------------------------------------------
  always_comb begin
    case (alu_sel)
      csi_pkg::ALU_ADD: alu_sum = {1'b0, alu_a} + {1'b0, alu_b};
      csi_pkg::ALU_SUB: alu_sum = {1'b0, alu_a} - {1'b0, alu_b};
      csi_pkg::ALU_AND: alu_sum = {1'b0, alu_a & alu_b};
      default: alu_sum = {1'b0, alu_a | alu_b};
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      alu_result_reg <= 8'h00;
    end else if (acc && op_code == csi_pkg::OP_ALU) begin
      alu_result_reg <= alu_sum[7:0];
    end
  end
  assign alu_result = alu_result_reg;

  // later assignments win: entry and mask beat set requests
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cpu_flags_register_reg <= `CSI_FLAGS_RESET;
    end else begin
      if (io_wr && io_addr == `CSI_A_FLAGS) begin
        cpu_flags_register_reg <= io_wdata;
      end
      if (acc && op_code == csi_pkg::OP_ALU) begin
        cpu_flags_register_reg[`CSI_C_BIT] <= alu_sum[8];
        cpu_flags_register_reg[`CSI_Z_BIT] <= (alu_sum[7:0] == 8'h00);
      end
      if ((ret_valid && handler_exit_op_reg) || (acc && op_code == csi_pkg::OP_SEI)) begin
        cpu_flags_register_reg[`CSI_GIE_BIT] <= 1'b1;
      end
      if ((acc && op_code == csi_pkg::OP_CLI) || irq_take) begin
        cpu_flags_register_reg[`CSI_GIE_BIT] <= 1'b0;
      end
    end
  end

  // one more retired instruction is owed after exit or unmask
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      defer_reg <= 1'b0;
    end else if ((ret_valid && handler_exit_op_reg) || (acc && op_code == csi_pkg::OP_SEI)) begin
      defer_reg <= 1'b1;
    end else if (insn_retire) begin
      defer_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      core_control_register_reg <= `CSI_CTRL_RESET;
      ien_reg <= `CSI_IEN_RESET;
    end else if (io_wr && io_addr == `CSI_A_CTRL) begin
      core_control_register_reg <= io_wdata;
    end else if (io_wr && io_addr == `CSI_A_IEN) begin
      ien_reg <= io_wdata[3:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata_reg <= 8'h00;
    end else if (io_rd) begin
      if (io_addr == `CSI_A_SP_LO) begin
        io_rdata_reg <= stack_pointer_reg[7:0];
      end else if (io_addr == `CSI_A_SP_HI) begin
        io_rdata_reg <= stack_pointer_reg[15:8];
      end else if (io_addr == `CSI_A_FLAGS) begin
        io_rdata_reg <= cpu_flags_register_reg;
      end else if (io_addr == `CSI_A_CTRL) begin
        io_rdata_reg <= core_control_register_reg;
      end else if (io_addr == `CSI_A_IEN) begin
        io_rdata_reg <= {4'h0, ien_reg};
      end else if (io_addr == `CSI_A_IFLG) begin
        io_rdata_reg <= {4'h0, flag_vec};
      end else begin
        io_rdata_reg <= 8'h00;
      end
    end
  end
  assign io_rdata = io_rdata_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_entry;
    st_reg == csi_pkg::S_WR_LO ##1 st_reg == csi_pkg::S_WR_HI
      ##1 st_reg == csi_pkg::S_VEC1 ##1 vector_valid;
  endsequence
  sequence s_exit;
    stk_re ##1 stk_re ##1 st_reg == csi_pkg::S_FIN1 ##1 ret_valid;
  endsequence

  a_push_dec: assert property (acc && op_code == csi_pkg::OP_PUSH |=> stk_we
    ##1 stack_pointer_reg == 16'($past(stack_pointer_reg, 2) - 16'h0001))
    else $error("push did not lower pointer by one");
  a_entry_four: assert property (irq_take |=> s_entry
    ##0 stack_pointer_reg == 16'($past(stack_pointer_reg, 4) - 16'h0002))
    else $error("entry not four cycles with pointer minus two");
  a_exit_four: assert property (acc && op_code == csi_pkg::OP_HANDLER_EXIT_OP |=> s_exit
    ##0 stack_pointer_reg == 16'($past(stack_pointer_reg, 4) + 16'h0002) ##1 gie)
    else $error("handler exit sequence wrong");
  a_take_gie: assert property (irq_take |=> !gie ##1 !gie)
    else $error("global enable not cleared on entry");
  a_cli_now: assert property (op_valid && op_code == csi_pkg::OP_CLI && !busy
    |-> !irq_take ##1 !gie)
    else $error("interrupt taken with mask op");
  a_gate_en: assert property (irq_take |-> gie && req_vec[win_idx]
    && ien_reg[win_idx])
    else $error("entry without enables");
  a_prio_low: assert property (irq_take
    |-> (req_vec & 4'((4'h1 << win_idx) - 4'h1)) == 4'h0)
    else $error("lower vector not preferred");
  a_sei_defer: assert property (acc && op_code == csi_pkg::OP_SEI
    |=> defer_reg && !irq_take)
    else $error("entry right after unmask");
  a_lock_off: assert property (lock_block |-> !irq_take)
    else $error("entry while locked section");
  a_vec_boot: assert property (irq_take && vector_table_relocate
    |=> irq_vector >= `CSI_BOOT_START)
    else $error("relocated vector below boot start");

endmodule

// *** csi_stack_ram.sv ***
// stack ram on the far side of the core's stack port
// assumes: read data is wanted one cycle after stk_re; writes land at the edge
`timescale 1ns/1ps
module csi_stack_ram (
  input wire logic clk_sys,
  input wire logic [15:0] stk_addr,
  input wire logic stk_we,
  input wire logic stk_re,
  input wire logic [7:0] stk_wdata,
  output logic [7:0] stk_rdata
);
  logic [7:0] mem [0:65535];
  initial stk_rdata = 8'h5a;
  always @(posedge clk_sys) begin
    if (stk_we) mem[stk_addr] <= stk_wdata;
    // outside a read the line toggles so stale data never looks valid
    stk_rdata <= stk_re ? mem[stk_addr] : ~stk_rdata;
  end
endmodule

// *** cpu_stack_and_interrupt_entry_tb.sv ***
// self-checking bench for the stack pointer and interrupt entry core
// assumes: csi_core, csi_pkg, csi_map.svh and csi_stack_ram compiled first
`timescale 1ns/1ps
`include "csi_map.svh"
module cpu_stack_and_interrupt_entry_tb;
  logic clk_sys = 1'b0, rst_n = 1'b0, op_valid = 1'b0, insn_retire = 1'b0;
  csi_pkg::csi_op_t op_code = csi_pkg::OP_NONE;
  csi_pkg::csi_alu_t alu_sel = csi_pkg::ALU_ADD;
  logic [7:0] op_data = 8'h00, alu_a = 8'h00, alu_b = 8'h00, io_wdata = 8'h00;
  logic [15:0] ret_pc = 16'h0000, pc_now = 16'h0100;
  logic [5:0] io_addr = 6'h00;
  logic io_wr = 1'b0, io_rd = 1'b0, reset_vector_relocate_fuse = 1'b1;
  logic application_lock_bit = 1'b0, boot_section_lock_bit = 1'b0;
  logic [3:0] irq_cond = 4'h0;
  logic busy, irq_take, vector_valid, ret_valid, stk_we, stk_re;
  logic [15:0] irq_vector, ret_pc_out, reset_vector, stk_addr, got;
  logic [7:0] alu_result, stk_wdata, stk_rdata, io_rdata, rd, d, exp8;
  int n_fail = 0, comparisons = 0, sp, pc, k;
  always #2.5 clk_sys = ~clk_sys;
  csi_core dut (.clk_sys, .rst_n, .op_valid, .op_code, .op_data, .ret_pc, .alu_sel,
    .alu_a, .alu_b, .insn_retire, .pc_now, .busy, .irq_take, .vector_valid, .irq_vector,
    .ret_valid, .ret_pc_out, .reset_vector, .alu_result, .stk_addr, .stk_we, .stk_re,
    .stk_wdata, .stk_rdata, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .irq_cond,
    .reset_vector_relocate_fuse, .application_lock_bit, .boot_section_lock_bit);
  csi_stack_ram ram (.clk_sys, .stk_addr, .stk_we, .stk_re, .stk_wdata, .stk_rdata);
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic iow(input logic [5:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    io_addr <= a;
    io_wdata <= v;
    io_wr <= 1'b1;
    @(posedge clk_sys);
    io_wr <= 1'b0;
  endtask
  task automatic ior(input logic [5:0] a);
    @(posedge clk_sys);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge clk_sys);
    io_rd <= 1'b0;
    #1 rd = io_rdata;
  endtask
  task automatic op(input csi_pkg::csi_op_t c, input logic [7:0] v);
    @(posedge clk_sys);
    op_valid <= 1'b1;
    op_code <= c;
    op_data <= v;
    ret_pc <= pc[15:0];
    pc_now <= pc[15:0];
    insn_retire <= (c != csi_pkg::OP_RET && c != csi_pkg::OP_HANDLER_EXIT_OP);
    @(posedge clk_sys);
    op_valid <= 1'b0;
    insn_retire <= 1'b0;
    for (k = 0; k < 20; k++) begin
      #1 if (ret_valid === 1'b1) got = ret_pc_out;
      if (busy === 1'b0) break;
      @(posedge clk_sys);
    end
    if (k >= 20) begin
      n_fail++;
      stop_test();
    end
  endtask
  task automatic pulse(input logic [3:0] m);
    @(posedge clk_sys);
    irq_cond <= m;
    @(posedge clk_sys);
    irq_cond <= 4'h0;
  endtask
  // retires instructions until one is taken; n is the retire that wins
  task automatic take(input int n, input logic [15:0] v);
    for (k = 1; k <= 8; k++) begin
      @(posedge clk_sys);
      insn_retire <= 1'b1;
      #1 if (irq_take === 1'b1) break;
    end
    chk(k, n);
    @(posedge clk_sys);
    insn_retire <= 1'b0;
    for (k = 1; k <= 8; k++) begin
      @(posedge clk_sys);
      #1 if (vector_valid === 1'b1) break;
    end
    chk(k, 3);
    chk(irq_vector, v);
    if (k > 8) stop_test();
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(40));
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(reset_vector, 16'h1c00);
    ior(`CSI_A_SP_HI);
    chk(rd, 8'h10);
    ior(`CSI_A_SP_LO);
    chk(rd, 8'hff);
    ior(`CSI_A_FLAGS);
    chk(rd, 8'h00);
    $display("test reset done");
    sp = $urandom_range(16'h10ff, 16'h0200);
    iow(`CSI_A_SP_HI, sp[15:8]);
    iow(`CSI_A_SP_LO, sp[7:0]);
    ior(`CSI_A_SP_HI);
    chk(rd, sp[15:8]);
    ior(`CSI_A_SP_LO);
    chk(rd, sp[7:0]);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      alu_sel <= csi_pkg::csi_alu_t'(i);
      alu_a <= 8'($urandom);
      alu_b <= 8'($urandom);
      op(csi_pkg::OP_ALU, 8'h00);
      exp8 = i == 0 ? alu_a + alu_b : i == 1 ? alu_a - alu_b : i == 2 ? alu_a & alu_b : alu_a | alu_b;
      chk(alu_result, exp8);
    end
    $display("test registers and alu done");
    pc = $urandom_range(16'h1bff, 16'h0100);
    d = 8'($urandom);
    op(csi_pkg::OP_PUSH, d);
    chk(ram.mem[sp], d);
    chk(stk_addr, sp - 1);
    op(csi_pkg::OP_POP, 8'h00);
    chk(stk_addr, sp);
    op(csi_pkg::OP_CALL, 8'h00);
    chk(stk_addr, sp - 2);
    chk({ram.mem[sp - 1], ram.mem[sp]}, pc);
    op(csi_pkg::OP_RET, 8'h00);
    chk(got, pc);
    chk(stk_addr, sp);
    $display("test stack ops done");
    iow(`CSI_A_IEN, 8'h02);
    pulse(4'h2);
    ior(`CSI_A_IFLG);
    chk(rd, 8'h02);
    op(csi_pkg::OP_SEI, 8'h00);
    take(2, 16'h0004);
    chk(stk_addr, sp - 2);
    chk({ram.mem[sp - 1], ram.mem[sp]}, pc);
    ior(`CSI_A_FLAGS);
    chk(rd[7], 1'b0);
    ior(`CSI_A_IFLG);
    chk(rd, 8'h00);
    op(csi_pkg::OP_HANDLER_EXIT_OP, 8'h00);
    chk(got, pc);
    chk(stk_addr, sp);
    ior(`CSI_A_FLAGS);
    chk(rd[7], 1'b1);
    $display("test entry and exit done");
    op(csi_pkg::OP_CLI, 8'h00);
    iow(`CSI_A_CTRL, 8'h02);
    pulse(4'h7);
    ior(`CSI_A_IFLG);
    chk(rd, 8'h07);
    iow(`CSI_A_IFLG, 8'h02);
    ior(`CSI_A_IFLG);
    chk(rd, 8'h05);
    iow(`CSI_A_IEN, 8'h05);
    op(csi_pkg::OP_SEI, 8'h00);
    take(2, 16'h1c02);
    op(csi_pkg::OP_HANDLER_EXIT_OP, 8'h00);
    take(2, 16'h1c06);
    $display("test priority and relocation done");
    // boot lock with relocated vectors blocks entry below boot start; level source waits
    @(posedge clk_sys);
    boot_section_lock_bit <= 1'b1;
    irq_cond <= 4'h8;
    iow(`CSI_A_IEN, 8'h08);
    op(csi_pkg::OP_HANDLER_EXIT_OP, 8'h00);
    chk(got, pc);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_sys);
      insn_retire <= 1'b1;
      #1 chk(irq_take, 1'b0);
    end
    @(posedge clk_sys);
    boot_section_lock_bit <= 1'b0;
    insn_retire <= 1'b0;
    take(2, 16'h1c08);
    $display("test lock and level done");
    stop_test();
  end
endmodule
